// ---- adcsf_core_model.sv ----
// conversion core model: one timed conversion per go request
`timescale 1ns/1ps
`default_nettype none
module adcsf_core_model (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic go,
   input wire logic [2:0] ch,
   input wire logic [9:0] data,
   input wire logic [3:0] len,
   output logic core_done,
   output logic [2:0] core_ch,
   output logic [9:0] core_data,
   output logic core_busy
);
   logic [3:0] cnt_reg;
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         cnt_reg <= 4'h0;
         core_busy <= 1'b0;
         core_done <= 1'b0;
         core_ch <= 3'h0;
      end else if (go) begin
         cnt_reg <= len;
         core_busy <= 1'b1;
         core_done <= 1'b0;
         core_ch <= ch;
      end else begin
         core_done <= (cnt_reg == 4'h1);
         if (cnt_reg != 4'h0) cnt_reg <= cnt_reg - 4'h1;
         if (cnt_reg == 4'h1) core_busy <= 1'b0;
      end
   end
   // data only valid with done; inverted every cycle otherwise, so stale values match again on alternate cycles
   always_ff @(posedge sys_clk) begin
      if (!rst_n) core_data <= 10'h000;
      else if (cnt_reg == 4'h1) core_data <= data;
      else core_data <= ~core_data;
   end
endmodule : adcsf_core_model
`default_nettype wire

// ---- adcsf_pkg.sv ----
// package: constants for the converter status-flag block
`default_nettype none
package adcsf_pkg;
   localparam int unsigned ADCSF_NUM_CH = 8;
   // register offsets (byte addresses, one word each)
   localparam logic [7:0] ADCSF_OFF_CTRL = 8'h00;
   localparam logic [7:0] ADCSF_OFF_MODE = 8'h04;
   localparam logic [7:0] ADCSF_OFF_CHEN = 8'h10;
   localparam logic [7:0] ADCSF_OFF_CHDIS = 8'h14;
   localparam logic [7:0] ADCSF_OFF_CHSR = 8'h18;
   localparam logic [7:0] ADCSF_OFF_STATUS = 8'h1C;
   localparam logic [7:0] ADCSF_OFF_LAST = 8'h20;
   localparam logic [7:0] ADCSF_OFF_INT_STAT = 8'h24;
   localparam logic [7:0] ADCSF_OFF_INT_MASK = 8'h28;
   localparam logic [7:0] ADCSF_OFF_RESULT0 = 8'h30;
   // field positions
   localparam int unsigned ADCSF_CTRL_START_BIT = 1;
   localparam int unsigned ADCSF_MODE_SLEEP_BIT = 5;
   localparam int unsigned ADCSF_ST_OVR_LSB = 8;
   localparam int unsigned ADCSF_ST_READY_BIT = 16;
   localparam int unsigned ADCSF_ST_GOVR_BIT = 17;
   localparam int unsigned ADCSF_ST_SLEEP_BIT = 18;
   // interrupt status bits
   localparam int unsigned ADCSF_IRQ_READY = 0;
   localparam int unsigned ADCSF_IRQ_OVR = 1;
   localparam int unsigned ADCSF_IRQ_GOVR = 2;
   localparam int unsigned ADCSF_IRQ_W = 3;
   localparam logic [31:0] ADCSF_RST_WORD = 32'h0000_0000;
endpackage : adcsf_pkg
`default_nettype wire

// ---- adcsf_top.sv ----
// status-flag logic of a converter control block
// How it works
// - reading a channel's result or the last-result register clears that channel's conversion-done flag.
// - a status read clears a channel overrun whose done flag is already clear, even beside a new completion.
// - a channel result read beside another channel's completion still sets global overrun when it is due.
// - disabling one channel beside a completion on another with its done flag set raises that overrun.
// - a status read beside a completion still clears or sets global overrun as the flags demand.
// - a channel result read clears only that channel's done flag, whatever else completes.
// - a channel disabled mid-conversion never gets its done flag raised.
// - sleep written while idle takes effect only after the next conversion completes.
// - result-ready clears only on a last-result read, never on a channel result read.
`timescale 1ns/1ps
`default_nettype none
module adcsf_top #(
   parameter int unsigned NUM_CH = adcsf_pkg::ADCSF_NUM_CH,
   parameter int unsigned RES_W = 10
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [7:0] bus_addr,
   input wire logic [31:0] bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   output logic [31:0] bus_rdata,
   input wire logic core_done,
   input wire logic [2:0] core_ch,
   input wire logic [RES_W-1:0] core_data,
   input wire logic core_busy,
   output logic [NUM_CH-1:0] ch_enable,
   output logic start_pulse,
   output logic sleep_active,
   output logic irq
);
   localparam int unsigned CHW = $clog2(NUM_CH);

   logic [NUM_CH-1:0] chen_reg;
   logic [NUM_CH-1:0] done_reg;
   logic [NUM_CH-1:0] ovr_reg;
   logic [NUM_CH-1:0] running_dis_reg;
   logic ready_reg;
   logic govr_reg;
   logic [RES_W-1:0] result_reg [NUM_CH];
   logic [RES_W-1:0] last_reg;
   logic [CHW-1:0] last_ch_reg;
   logic sleep_req_reg;
   logic sleep_reg;
   logic start_reg;
   logic [adcsf_pkg::ADCSF_IRQ_W-1:0] istat_reg;
   logic [adcsf_pkg::ADCSF_IRQ_W-1:0] imask_reg;
   logic irq_reg;
   logic [31:0] rdata_reg;

   // decoded per-channel result-register hit
   function automatic logic res_hit(input logic [7:0] a, input int unsigned ch);
      res_hit = (a == 8'(adcsf_pkg::ADCSF_OFF_RESULT0 + 8'(ch * 4)));
   endfunction : res_hit

   logic rd_status;
   logic rd_last;
   logic wr_ctrl;
   logic wr_mode;
   logic wr_chen;
   logic wr_chdis;
   logic [NUM_CH-1:0] rd_res;
   logic [NUM_CH-1:0] done_ev;
   logic [NUM_CH-1:0] dis_now;
   logic store;
   logic any_ovr_ev;
   logic govr_ev;

   assign rd_status = bus_rd && bus_addr == adcsf_pkg::ADCSF_OFF_STATUS;
   assign rd_last = bus_rd && bus_addr == adcsf_pkg::ADCSF_OFF_LAST;
   assign wr_ctrl = bus_wr && bus_addr == adcsf_pkg::ADCSF_OFF_CTRL;
   assign wr_mode = bus_wr && bus_addr == adcsf_pkg::ADCSF_OFF_MODE;
   assign wr_chen = bus_wr && bus_addr == adcsf_pkg::ADCSF_OFF_CHEN;
   assign wr_chdis = bus_wr && bus_addr == adcsf_pkg::ADCSF_OFF_CHDIS;
   assign dis_now = wr_chdis ? bus_wdata[NUM_CH-1:0] : '0;

   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++) begin : g_ch
         assign rd_res[g] = bus_rd && res_hit(bus_addr, g);
         // completion counts only for a channel still enabled at its end
         assign done_ev[g] = core_done && core_ch == 3'(g) && chen_reg[g] && !running_dis_reg[g];
      end
   endgenerate

   assign store = |done_ev;
   assign any_ovr_ev = |(done_ev & done_reg);
   // previous last result unread; reads or disables elsewhere do not mask it
   assign govr_ev = store && ready_reg;

   // events feeding the interrupt status bits
   logic [adcsf_pkg::ADCSF_IRQ_W-1:0] irq_ev;
   assign irq_ev[adcsf_pkg::ADCSF_IRQ_READY] = store;
   assign irq_ev[adcsf_pkg::ADCSF_IRQ_OVR] = any_ovr_ev;
   assign irq_ev[adcsf_pkg::ADCSF_IRQ_GOVR] = govr_ev;

   // channel enables; a channel dropped mid-conversion is remembered
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         chen_reg <= '0;
         running_dis_reg <= '0;
      end else begin
         chen_reg <= (chen_reg | (wr_chen ? bus_wdata[NUM_CH-1:0] : '0)) & ~dis_now;
         for (int i = 0; i < NUM_CH; i++) begin
            if (core_done && core_ch == 3'(i))
               running_dis_reg[i] <= 1'b0;
            else if (dis_now[i] && core_busy && core_ch == 3'(i))
               running_dis_reg[i] <= 1'b1;
         end
      end
   end

   // per-channel done and overrun flags; set wins over clear
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         done_reg <= '0;
         ovr_reg <= '0;
      end else begin
         for (int i = 0; i < NUM_CH; i++) begin
            if (done_ev[i])
               done_reg[i] <= 1'b1;
            else if (rd_res[i] || (rd_last && last_ch_reg == CHW'(i)))
               done_reg[i] <= 1'b0; // only the addressed channel
            if (done_ev[i] && done_reg[i])
               ovr_reg[i] <= 1'b1; // also beside a disable elsewhere
            else if (rd_status && !done_reg[i])
               ovr_reg[i] <= 1'b0;
         end
      end
   end

   // result-ready and global overrun
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ready_reg <= 1'b0;
         govr_reg <= 1'b0;
      end else begin
         if (store)
            ready_reg <= 1'b1;
         else if (rd_last)
            ready_reg <= 1'b0; // channel reads leave it alone
         if (govr_ev)
            govr_reg <= 1'b1;
         else if (rd_status)
            govr_reg <= 1'b0; // a read beside a completion clears unless ready_reg is also set
      end
   end

   // result storage
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         last_reg <= '0;
         last_ch_reg <= '0;
         for (int i = 0; i < NUM_CH; i++)
            result_reg[i] <= '0;
      end else if (store) begin
         last_reg <= core_data;
         last_ch_reg <= CHW'(core_ch);
         result_reg[core_ch[CHW-1:0]] <= core_data;
      end
   end

   // deferred sleep: armed by mode write, entered at the next completion
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         sleep_req_reg <= 1'b0;
         sleep_reg <= 1'b0;
         start_reg <= 1'b0;
      end else begin
         start_reg <= wr_ctrl && bus_wdata[adcsf_pkg::ADCSF_CTRL_START_BIT] && !sleep_reg;
         if (wr_mode)
            sleep_req_reg <= bus_wdata[adcsf_pkg::ADCSF_MODE_SLEEP_BIT];
         if (wr_mode && !bus_wdata[adcsf_pkg::ADCSF_MODE_SLEEP_BIT])
            sleep_reg <= 1'b0;
         else if (core_done && sleep_req_reg)
            sleep_reg <= 1'b1; // never while idle, only after a conversion
         else if (wr_ctrl && bus_wdata[adcsf_pkg::ADCSF_CTRL_START_BIT])
            sleep_reg <= 1'b0; // wake for the requested conversion
      end
   end

   // interrupt status, write-one-to-clear, set wins
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         istat_reg <= '0;
         imask_reg <= '0;
         irq_reg <= 1'b0;
      end else begin
         for (int i = 0; i < adcsf_pkg::ADCSF_IRQ_W; i++) begin
            if (irq_ev[i])
               istat_reg[i] <= 1'b1;
            else if (bus_wr && bus_addr == adcsf_pkg::ADCSF_OFF_INT_STAT && bus_wdata[i])
               istat_reg[i] <= 1'b0;
         end
         if (bus_wr && bus_addr == adcsf_pkg::ADCSF_OFF_INT_MASK)
            imask_reg <= bus_wdata[adcsf_pkg::ADCSF_IRQ_W-1:0];
         irq_reg <= |(istat_reg & imask_reg);
      end
   end

   // read data, one cycle after the strobe; unmapped reads zero
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         rdata_reg <= adcsf_pkg::ADCSF_RST_WORD;
      end else if (bus_rd) begin
         rdata_reg <= '0;
         case (bus_addr)
            adcsf_pkg::ADCSF_OFF_MODE:
               rdata_reg[adcsf_pkg::ADCSF_MODE_SLEEP_BIT] <= sleep_req_reg;
            adcsf_pkg::ADCSF_OFF_CHSR: rdata_reg[NUM_CH-1:0] <= chen_reg;
            adcsf_pkg::ADCSF_OFF_STATUS: begin
               rdata_reg[NUM_CH-1:0] <= done_reg;
               rdata_reg[adcsf_pkg::ADCSF_ST_OVR_LSB +: NUM_CH] <= ovr_reg;
               rdata_reg[adcsf_pkg::ADCSF_ST_READY_BIT] <= ready_reg;
               rdata_reg[adcsf_pkg::ADCSF_ST_GOVR_BIT] <= govr_reg;
               rdata_reg[adcsf_pkg::ADCSF_ST_SLEEP_BIT] <= sleep_reg;
            end
            adcsf_pkg::ADCSF_OFF_LAST: rdata_reg[RES_W-1:0] <= last_reg;
            adcsf_pkg::ADCSF_OFF_INT_STAT: rdata_reg[adcsf_pkg::ADCSF_IRQ_W-1:0] <= istat_reg;
            adcsf_pkg::ADCSF_OFF_INT_MASK: rdata_reg[adcsf_pkg::ADCSF_IRQ_W-1:0] <= imask_reg;
            default: begin
               for (int i = 0; i < NUM_CH; i++)
                  if (res_hit(bus_addr, i))
                     rdata_reg[RES_W-1:0] <= result_reg[i];
            end
         endcase
      end else begin
         rdata_reg <= '0;
      end
   end

   assign bus_rdata = rdata_reg;
   assign ch_enable = chen_reg;
   assign start_pulse = start_reg;
   assign sleep_active = sleep_reg;
   assign irq = irq_reg;

   // a result read never touches result-ready
   AST_READY_SET: assert property (@(posedge sys_clk) disable iff (!rst_n)
      store |=> ready_reg)
      else $error("ready not set by a completion");
   AST_READY_KEEP: assert property (@(posedge sys_clk) disable iff (!rst_n)
      ready_reg && !store && !rd_last |=> ready_reg)
      else $error("ready lost without last read");
   AST_READY_CLR: assert property (@(posedge sys_clk) disable iff (!rst_n)
      rd_last && !store |=> !ready_reg)
      else $error("ready kept after last read");
   AST_DONE_CLEAR: assert property (@(posedge sys_clk) disable iff (!rst_n)
      rd_res[0] && !done_ev[0] |=> !done_reg[0])
      else $error("done not cleared by result read");
   AST_GOVR_SET: assert property (@(posedge sys_clk) disable iff (!rst_n)
      store && ready_reg |=> govr_reg)
      else $error("global overrun missed");
   AST_GOVR_RD_SET: assert property (@(posedge sys_clk) disable iff (!rst_n)
      rd_status && store && ready_reg |=> govr_reg)
      else $error("global overrun missed beside status read");
   AST_GOVR_CLR: assert property (@(posedge sys_clk) disable iff (!rst_n)
      rd_status && govr_reg && !ready_reg |=> !govr_reg)
      else $error("global overrun not cleared");
   AST_GOVR_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
      govr_reg && !rd_status |=> govr_reg)
      else $error("global overrun lost without status read");
   // arming from idle: an older request could legally fire at the same completion
   sequence s_sleep_idle;
      wr_mode && bus_wdata[adcsf_pkg::ADCSF_MODE_SLEEP_BIT] && !sleep_reg && !sleep_req_reg;
   endsequence
   AST_SLEEP_WAIT: assert property (@(posedge sys_clk) disable iff (!rst_n)
      s_sleep_idle ##1 !core_done |=> !sleep_reg)
      else $error("sleep before completion");
   AST_SLEEP_ENTER: assert property (@(posedge sys_clk) disable iff (!rst_n)
      core_done && sleep_req_reg && !wr_mode |=> sleep_reg)
      else $error("sleep not entered after completion");

   // per-channel flag checks, so no channel is left unwatched
   genvar c;
   generate
      for (c = 0; c < NUM_CH; c++) begin : g_chk
         AST_DONE_SET: assert property (@(posedge sys_clk) disable iff (!rst_n)
            done_ev[c] |=> done_reg[c])
            else $error("done not set by completion");
         AST_ONLY_OWN: assert property (@(posedge sys_clk) disable iff (!rst_n)
            rd_res[c] && done_reg[(c + 1) % NUM_CH] && !rd_last |=> done_reg[(c + 1) % NUM_CH])
            else $error("other done flag cleared");
         AST_LAST_CLEAR: assert property (@(posedge sys_clk) disable iff (!rst_n)
            rd_last && last_ch_reg == CHW'(c) && !done_ev[c] |=> !done_reg[c])
            else $error("done not cleared by last read");
         AST_OVR_SET: assert property (@(posedge sys_clk) disable iff (!rst_n)
            done_ev[c] && done_reg[c] |=> ovr_reg[c])
            else $error("overrun not set");
         AST_OVR_CLR: assert property (@(posedge sys_clk) disable iff (!rst_n)
            rd_status && ovr_reg[c] && !done_reg[c] |=> !ovr_reg[c])
            else $error("overrun kept");
         AST_OVR_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
            ovr_reg[c] && !rd_status |=> ovr_reg[c])
            else $error("overrun lost without status read");
         AST_DIS_NO_DONE: assert property (@(posedge sys_clk) disable iff (!rst_n)
            running_dis_reg[c] && !done_reg[c] |=> !done_reg[c])
            else $error("disabled channel flagged");
         AST_OFF_NO_DONE: assert property (@(posedge sys_clk) disable iff (!rst_n)
            !chen_reg[c] && !done_reg[c] |=> !done_reg[c])
            else $error("channel off yet flagged");
      end
   endgenerate
endmodule : adcsf_top
`default_nettype wire

// ---- adcsf_top_tb.sv ----
// self-checking bench for the converter status-flag block
`timescale 1ns/1ps
`default_nettype none
module adcsf_top_tb;
   localparam logic [7:0] ST = adcsf_pkg::ADCSF_OFF_STATUS;
   localparam logic [7:0] LAST = adcsf_pkg::ADCSF_OFF_LAST;
   localparam logic [7:0] RES0 = adcsf_pkg::ADCSF_OFF_RESULT0;
   localparam logic [7:0] IMASK = adcsf_pkg::ADCSF_OFF_INT_MASK;
   localparam logic [7:0] ISTAT = adcsf_pkg::ADCSF_OFF_INT_STAT;
   localparam logic [7:0] CHDIS = adcsf_pkg::ADCSF_OFF_CHDIS;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] bus_addr = 8'h00;
   logic [31:0] bus_wdata = 32'h0;
   logic bus_wr = 1'b0;
   logic bus_rd = 1'b0;
   logic [31:0] bus_rdata, rv;
   logic core_done, core_busy, start_pulse, sleep_active, irq;
   logic [2:0] core_ch;
   logic [9:0] core_data;
   logic [7:0] ch_enable;
   logic go = 1'b0;
   logic [2:0] m_ch = 3'h0;
   logic [9:0] m_data = 10'h000;
   int num_errors = 0;
   int samples_checked = 0;
   int cyc = 0;
   always #20 sys_clk = ~sys_clk;
   adcsf_top i_adcsf_top (.sys_clk(sys_clk), .rst_n(rst_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
      .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .core_done(core_done), .core_ch(core_ch),
      .core_data(core_data), .core_busy(core_busy), .ch_enable(ch_enable), .start_pulse(start_pulse),
      .sleep_active(sleep_active), .irq(irq));
   adcsf_core_model i_adcsf_core_model (.sys_clk(sys_clk), .rst_n(rst_n), .go(go), .ch(m_ch),
      .data(m_data), .len(4'h6), .core_done(core_done), .core_ch(core_ch), .core_data(core_data),
      .core_busy(core_busy));
   task automatic wrap_up;
      $display("errors %0d checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : wrap_up
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 3000) begin
         num_errors++;
         wrap_up();
      end
   end
   task automatic chk_w(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] %0t word %h expected %h", $time, g, e);
      end
   endtask : chk_w
   task automatic chk_b(input logic g, input logic e);
      samples_checked++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] %0t flag %b expected %b", $time, g, e);
      end
   endtask : chk_b
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      bus_addr <= a;
      bus_wdata <= d;
      bus_wr <= 1'b1;
      @(posedge sys_clk);
      bus_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge sys_clk);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge sys_clk);
      bus_rd <= 1'b0;
      #1;
      rv = bus_rdata;
   endtask : rd
   task automatic st(input logic [31:0] e);
      rd(ST);
      chk_w(rv, e);
   endtask : st
   task automatic settle;
      repeat (2) @(posedge sys_clk);
      #1;
   endtask : settle
   // op 1 reads, op 2 writes; lead 0 lands the access on the done edge, lead 2 mid-conversion
   task automatic conv(input logic [2:0] c, input logic [9:0] d, input int lead, input int op,
      input logic [7:0] a, input logic [31:0] w);
      @(posedge sys_clk);
      m_ch <= c;
      m_data <= d;
      go <= 1'b1;
      @(posedge sys_clk);
      go <= 1'b0;
      repeat (5 - lead) @(posedge sys_clk);
      if (op == 1) rd(a);
      else if (op == 2) wr(a, w);
      repeat (3) @(posedge sys_clk);
   endtask : conv
   initial begin
      repeat (12) @(posedge sys_clk);
      rst_n <= 1'b1;
      st(32'h0);
      chk_w({24'h0, ch_enable}, 32'h0);
      wr(adcsf_pkg::ADCSF_OFF_CHEN, 32'h0F);
      rd(adcsf_pkg::ADCSF_OFF_CHSR);
      chk_w(rv, 32'h0F);
      conv(3'h0, 10'h155, 0, 0, 0, 0);
      st(32'h0001_0001);
      rd(RES0);
      chk_w(rv, 32'h155);
      st(32'h0001_0000);
      rd(LAST);
      st(32'h0);
      conv(3'h1, 10'h0AA, 0, 0, 0, 0);
      conv(3'h1, 10'h0AB, 0, 0, 0, 0);
      st(32'h0003_0202);
      st(32'h0001_0202);
      rd(RES0 + 8'h04);
      chk_w(rv, 32'h0AB);
      conv(3'h1, 10'h0AC, 0, 1, ST, 0);
      chk_w(rv, 32'h0001_0200);
      rd(LAST);
      conv(3'h0, 10'h0B0, 0, 1, ST, 0);
      chk_w(rv, 32'h0002_0000);
      st(32'h0001_0001);
      conv(3'h2, 10'h0C2, 0, 0, 0, 0);
      st(32'h0003_0005);
      conv(3'h0, 10'h0B1, 0, 1, RES0 + 8'h04, 0);
      chk_w(rv, 32'h0AC);
      st(32'h0003_0105);
      conv(3'h3, 10'h0D3, 0, 1, RES0 + 8'h08, 0);
      chk_w(rv, 32'h0C2);
      st(32'h0003_0109);
      rd(RES0);
      rd(LAST);
      st(32'h0000_0100);
      st(32'h0);
      conv(3'h1, 10'h011, 0, 0, 0, 0);
      conv(3'h1, 10'h012, 0, 2, CHDIS, 32'h08);
      st(32'h0003_0202);
      conv(3'h2, 10'h022, 2, 2, CHDIS, 32'h04);
      st(32'h0001_0202);
      chk_w({24'h0, ch_enable}, 32'h03);
      // old events are sticky, so clear them before arming the mask
      wr(IMASK, 32'h0);
      wr(ISTAT, 32'h7);
      settle();
      chk_b(irq, 1'b0);
      wr(IMASK, 32'h1);
      conv(3'h0, 10'h033, 0, 0, 0, 0);
      #1;
      chk_b(irq, 1'b1);
      rd(ISTAT);
      chk_w(rv, 32'h5);
      wr(IMASK, 32'h0);
      settle();
      chk_b(irq, 1'b0);
      wr(IMASK, 32'h1);
      settle();
      chk_b(irq, 1'b1);
      wr(ISTAT, 32'h1);
      settle();
      chk_b(irq, 1'b0);
      wr(adcsf_pkg::ADCSF_OFF_MODE, 32'h20);
      wr(adcsf_pkg::ADCSF_OFF_CTRL, 32'h02);
      #1;
      chk_b(start_pulse, 1'b1);
      settle();
      chk_b(sleep_active, 1'b0);
      conv(3'h0, 10'h044, 0, 0, 0, 0);
      #1;
      chk_b(sleep_active, 1'b1);
      // a start while asleep wakes the core but gives no pulse
      wr(adcsf_pkg::ADCSF_OFF_CTRL, 32'h02);
      #1;
      chk_b(start_pulse, 1'b0);
      chk_b(sleep_active, 1'b0);
      wrap_up();
   end
endmodule : adcsf_top_tb
`default_nettype wire
